/* gci_line_io_pkg.sv */
// Package with command codes, field layouts, reset values and timing for the line I/O registers.
package gci_line_io_pkg;

  localparam int NUM_CH = 4;
  localparam int NUM_IO = 5;

  // Monitor channel command bytes; bit 0 set means read.
  localparam logic [7:0] CMD_OPMODE_WR = 8'h4a;
  localparam logic [7:0] CMD_OPMODE_RD = 8'h4b;
  localparam logic [7:0] CMD_IO_WR = 8'h52;
  localparam logic [7:0] CMD_IO_RD = 8'h53;
  localparam logic [7:0] CMD_DEB_WR = 8'hc8;
  localparam logic [7:0] CMD_DEB_RD = 8'hc9;
  localparam logic [7:0] CMD_GK_WR = 8'he8;
  localparam logic [7:0] CMD_GK_RD = 8'he9;
  localparam logic [7:0] CMD_RT_RD = 8'h4d;
  localparam logic [7:0] CMD_RT_RD_CLR = 8'h4f;
  localparam logic [7:0] CMD_MASK_WR = 8'h6c;
  localparam logic [7:0] CMD_MASK_RD = 8'h6d;
  localparam int CMD_RW_BIT = 0;
  localparam int CMD_CLR_BIT = 1;

  // Operating mode register fields.
  localparam int OPM_VOICE_OUTPUT_IDLE_MODE_BIT = 5;
  localparam int OPM_LPM_BIT = 4;
  localparam logic [7:0] OPMODE_RESET = 8'h0f;

  // Hook debounce control register fields.
  localparam int DEB_MUX_BIT = 7;
  localparam int DEB_POL_BIT = 6;
  localparam int DEB_TIME_LSB = 2;
  localparam int DEB_CHOP_BIT = 0;
  localparam logic [7:0] DEB_RESET = 8'h20;

  // Ground key sampling and interrupt mask resets.
  localparam logic [3:0] GK_RESET = 4'h0;
  localparam logic [7:0] MASK_RESET = 8'hff;

  // Line I/O pin order inside a channel's pin vector.
  localparam int IO_CD1 = 0;
  localparam int IO_CD2 = 1;
  localparam int IO_C3 = 2;
  localparam int IO_C4 = 3;
  localparam int IO_C5 = 4;

  // Timing: clock rate, millisecond tick and chopper half period.
  localparam int CLK_MHZ = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS * CLK_MHZ / 1000;
  localparam int CHOP_KHZ = 256;
  localparam int CHOP_HALF_CYCLES = CLK_MHZ * 1000 / (2 * CHOP_KHZ);
  localparam logic [7:0] CHOP_HALF_LAST = 8'(CHOP_HALF_CYCLES - 1);

  typedef struct packed {
    logic is_ci;
    logic [1:0] chan;
    logic [7:0] data;
  } link_word_t;

  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_DATA = 3'b010,
    ST_ANSWER = 3'b100
  } mon_state_t;

endpackage : gci_line_io_pkg

/* gci_line_io_config_regs.sv */
// Monitor channel register bank for line I/O, hook debounce, ground key and real-time data.
//
// Contract
// - Operating mode written by 4Ah, read by 4Bh; command bit 0 selects read.
// - Idle voice output: 0 ties to reference through resistor, 1 high impedance.
// - Legacy low power bit is stored only, no effect.
// - Controller writes reserved bits as 0; reads may return stored values.
// - Command 53h returns C7, C6, muxed hook, C5, C4, C3, CD2, CD1.
// - Read-back shows actual pin levels of addressed channel, any direction.
// - Muxed hook bit is meaningful only while frame multiplexing is on.
// - Input pins send debounced CD1, CD2 or muxed hook, and C3 upstream.
// - Output pins follow downstream C/I bits and are not echoed upstream; with multiplexing on, bit 1 is sent unmasked.
// - Command 52h writes output states until next downstream C/I field.
// - Debounce register C8h/C9h, global: mux, polarity, time, chopper enable.
// - Mux enable turns multiplexing on; polarity 1 gives low-going strobe.
// - Muxed hook changes only after CD1 stable for debounce time.
// - Chopper enable turns chopper clock on; off by default.
// - Ground key register E8h/E9h sets sampling period before upstream C/I.
// - Real-time read 4Dh or 4Fh; command bit 1 clears interrupt.
// - Real-time byte has two bits per channel, channel 1 lowest.
// - Mask register 6Ch/6Dh, one bit per data bit, 1 masks, default.
// - Change of a masked real-time bit never pulls interrupt low.
// - Channel with active flag 0 is inactive and uses idle voice mode.
`timescale 1ns/10ps
`default_nettype none

module gci_line_io_config_regs
  import gci_line_io_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire link_word_t link_word,
  output logic up_valid,
  output logic [7:0] up_byte,
  output logic [NUM_CH-1:0][2:0] ci_up,
  input wire logic [NUM_CH-1:0][NUM_IO-1:0] io_dir,
  input wire logic [NUM_CH-1:0][NUM_IO-1:0] pin_in,
  output logic [NUM_CH-1:0][NUM_IO-1:0] pin_out,
  output logic [NUM_CH-1:0][NUM_IO-1:0] pin_oe,
  output logic [NUM_CH-1:0] control_pin_six,
  output logic [NUM_CH-1:0] control_pin_seven,
  input wire logic [NUM_CH-1:0] channel_active_flag,
  output logic [NUM_CH-1:0] voice_output_hiz,
  output logic [NUM_CH-1:0] voice_output_ref,
  output logic multiplex_strobe,
  output logic chopper_clk,
  output logic int_n
);

  function automatic logic tick_due(input logic [3:0] cnt, input logic [3:0] limit);
    tick_due = (cnt >= limit);
  endfunction : tick_due

  // Link clock and word are both pins: two flops each, third flop for the edge.
  logic [2:0] lclk_q;
  link_word_t lw_s1_q, lw_s2_q;
  logic [NUM_CH-1:0][NUM_IO-1:0] pin_s1_q, pin_s2_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lclk_q <= 3'h0;
      lw_s1_q <= '0;
      lw_s2_q <= '0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      lclk_q <= {lclk_q[1:0], link_clk};
      lw_s1_q <= link_word;
      lw_s2_q <= lw_s1_q;
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire link_take = lclk_q[1] & ~lclk_q[2];
  wire mon_take = link_take & ~lw_s2_q.is_ci;
  wire ci_take = link_take & lw_s2_q.is_ci;
  wire [7:0] rx = lw_s2_q.data;
  wire [1:0] rx_ch = lw_s2_q.chan;

  // Registers.
  logic [7:0] opmode_q, deb_q, mask_q, cmd_q, rt_q;
  logic [3:0] gk_q;
  logic [1:0] ch_q;
  logic pend_q;
  mon_state_t st_q;
  logic [NUM_CH-1:0][NUM_IO-1:0] drive_q;

  wire mux_en = deb_q[DEB_MUX_BIT];
  wire [3:0] deb_time = deb_q[DEB_TIME_LSB +: 4];

  // Millisecond tick and multiplex strobe phase from one divider.
  logic [31:0] ms_cnt_q;
  logic phase_q;
  wire ms_tick = (ms_cnt_q == 32'(MS_TICK_CYCLES - 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ms_cnt_q <= 32'h0;
      phase_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
      if (ms_tick) begin
        phase_q <= ~phase_q;
      end
    end
  end

  // Per-channel debounce and ground key filtering.
  logic [NUM_CH-1:0] a_src_q, hook_src_q, cda_q, hook_q, cdb_q;
  logic [NUM_CH-1:0][3:0] deb_a_q, deb_h_q, gk_cnt_q;
  logic [NUM_CH-1:0] gk_src;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      gk_src[c] = mux_en ? hook_q[c] : pin_s2_q[c][IO_CD2];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      a_src_q <= '0;
      hook_src_q <= '0;
      cda_q <= '0;
      hook_q <= '0;
      cdb_q <= '0;
      deb_a_q <= '0;
      deb_h_q <= '0;
      gk_cnt_q <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        // With multiplexing the shared CD1 line carries hook in the strobe phase.
        if (!mux_en || !phase_q) begin
          a_src_q[c] <= pin_s2_q[c][IO_CD1];
        end
        if (mux_en && phase_q) begin
          hook_src_q[c] <= pin_s2_q[c][IO_CD1];
        end
        if (a_src_q[c] == cda_q[c]) begin
          deb_a_q[c] <= 4'h0;
        end else if (tick_due(deb_a_q[c], deb_time)) begin
          cda_q[c] <= a_src_q[c];
          deb_a_q[c] <= 4'h0;
        end else if (ms_tick) begin
          deb_a_q[c] <= deb_a_q[c] + 4'h1;
        end
        if (hook_src_q[c] == hook_q[c]) begin
          deb_h_q[c] <= 4'h0;
        end else if (tick_due(deb_h_q[c], deb_time)) begin
          hook_q[c] <= hook_src_q[c];
          deb_h_q[c] <= 4'h0;
        end else if (ms_tick) begin
          deb_h_q[c] <= deb_h_q[c] + 4'h1;
        end
        if (tick_due(gk_cnt_q[c], gk_q)) begin
          cdb_q[c] <= gk_src[c];
          gk_cnt_q[c] <= 4'h0;
        end else if (ms_tick) begin
          gk_cnt_q[c] <= gk_cnt_q[c] + 4'h1;
        end
      end
    end
  end

  // Real-time byte: channel c uses bits 2c (debounced) and 2c+1.
  logic [7:0] rt_now;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      rt_now[2*c] = cda_q[c];
      rt_now[2*c+1] = cdb_q[c];
    end
  end

  wire [7:0] rt_change = (rt_now ^ rt_q) & ~mask_q;
  wire rt_clear = (st_q == ST_ANSWER) && (cmd_q == CMD_RT_RD_CLR);

  // Read-back of the addressed channel's real pin levels.
  wire [NUM_IO-1:0] rb_pins = pin_s2_q[ch_q];
  wire [7:0] io_readback = {control_pin_seven[ch_q], control_pin_six[ch_q], hook_q[ch_q],
                            rb_pins[IO_C5], rb_pins[IO_C4], rb_pins[IO_C3],
                            rb_pins[IO_CD2], rb_pins[IO_CD1]};

  logic [7:0] rd_data;
  always_comb begin
    case (cmd_q)
      CMD_OPMODE_RD: rd_data = opmode_q;
      CMD_IO_RD: rd_data = io_readback;
      CMD_DEB_RD: rd_data = deb_q;
      CMD_GK_RD: rd_data = {4'h0, gk_q};
      CMD_RT_RD, CMD_RT_RD_CLR: rd_data = rt_q;
      CMD_MASK_RD: rd_data = mask_q;
      default: rd_data = 8'h00;
    endcase
  end

  wire cmd_known_rd = (rx == CMD_OPMODE_RD) || (rx == CMD_IO_RD) || (rx == CMD_DEB_RD) ||
                      (rx == CMD_GK_RD) || (rx == CMD_RT_RD) || (rx == CMD_RT_RD_CLR) ||
                      (rx == CMD_MASK_RD);
  wire cmd_known_wr = (rx == CMD_OPMODE_WR) || (rx == CMD_IO_WR) || (rx == CMD_DEB_WR) ||
                      (rx == CMD_GK_WR) || (rx == CMD_MASK_WR);
  wire wr_take = (st_q == ST_DATA) && mon_take;

  // Command sequencer: a read answers once, a write consumes one data byte.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= ST_CMD;
      cmd_q <= 8'h00;
      ch_q <= 2'h0;
      up_valid <= 1'b0;
      up_byte <= 8'h00;
    end else begin
      up_valid <= 1'b0;
      case (st_q)
        ST_CMD: begin
          if (mon_take && (cmd_known_rd || cmd_known_wr)) begin
            cmd_q <= rx;
            ch_q <= rx_ch;
            st_q <= rx[CMD_RW_BIT] ? ST_ANSWER : ST_DATA;
          end
        end
        ST_DATA: begin
          if (mon_take) begin
            st_q <= ST_CMD;
          end
        end
        ST_ANSWER: begin
          up_valid <= 1'b1;
          up_byte <= rd_data;
          st_q <= ST_CMD;
        end
        default: st_q <= ST_CMD;
      endcase
    end
  end

  // Register writes, real-time capture and interrupt pending.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opmode_q <= OPMODE_RESET;
      deb_q <= DEB_RESET;
      gk_q <= GK_RESET;
      mask_q <= MASK_RESET;
      rt_q <= 8'h00;
      pend_q <= 1'b0;
    end else begin
      if (wr_take && cmd_q == CMD_OPMODE_WR) begin
        opmode_q <= rx;
      end
      if (wr_take && cmd_q == CMD_DEB_WR) begin
        deb_q <= rx;
      end
      if (wr_take && cmd_q == CMD_GK_WR) begin
        gk_q <= rx[3:0];
      end
      if (wr_take && cmd_q == CMD_MASK_WR) begin
        mask_q <= rx;
      end
      rt_q <= rt_now;
      // A change in the clearing cycle keeps the interrupt pending.
      if (|rt_change) begin
        pend_q <= 1'b1;
      end else if (rt_clear) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Output pin levels: downstream C/I field per channel, or a 52h write.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      drive_q <= '0;
      control_pin_six <= '0;
      control_pin_seven <= '0;
      pin_oe <= '0;
    end else begin
      pin_oe <= io_dir;
      if (ci_take) begin
        drive_q[rx_ch] <= rx[NUM_IO-1:0];
      end else if (wr_take && cmd_q == CMD_IO_WR) begin
        drive_q[ch_q] <= rx[NUM_IO-1:0];
        control_pin_six[ch_q] <= rx[6];
        control_pin_seven[ch_q] <= rx[7];
      end
    end
  end

  // Pin, upstream C/I, voice and interrupt outputs all leave from flops.
  logic [7:0] chop_cnt_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      ci_up <= '0;
      voice_output_hiz <= '0;
      voice_output_ref <= '0;
      multiplex_strobe <= 1'b0;
      chopper_clk <= 1'b0;
      chop_cnt_q <= 8'h00;
      int_n <= 1'b1;
    end else begin
      pin_out <= drive_q;
      for (int c = 0; c < NUM_CH; c++) begin
        // Output-direction CD1 and C3 are masked, CD2 only while multiplexing is off, so their levels are not echoed.
        ci_up[c] <= {pin_s2_q[c][IO_C3] & ~io_dir[c][IO_C3],
                     cdb_q[c] & ~(io_dir[c][IO_CD2] & ~mux_en),
                     cda_q[c] & ~io_dir[c][IO_CD1]};
        voice_output_hiz[c] <= ~channel_active_flag[c] & opmode_q[OPM_VOICE_OUTPUT_IDLE_MODE_BIT];
        voice_output_ref[c] <= ~channel_active_flag[c] & ~opmode_q[OPM_VOICE_OUTPUT_IDLE_MODE_BIT];
      end
      multiplex_strobe <= (mux_en & phase_q) ^ deb_q[DEB_POL_BIT];
      if (!deb_q[DEB_CHOP_BIT]) begin
        chopper_clk <= 1'b0;
        chop_cnt_q <= 8'h00;
      end else if (chop_cnt_q == CHOP_HALF_LAST) begin
        chopper_clk <= ~chopper_clk;
        chop_cnt_q <= 8'h00;
      end else begin
        chop_cnt_q <= chop_cnt_q + 8'h01;
      end
      int_n <= ~pend_q;
    end
  end

endmodule : gci_line_io_config_regs

`default_nettype wire

/* gci_line_io_chk.sv */
// Concurrent checks on the ports of the line I/O register bank.
`timescale 1ns/10ps
`default_nettype none

module gci_line_io_chk
  import gci_line_io_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic up_valid,
  input wire logic [7:0] up_byte,
  input wire logic [NUM_CH-1:0][2:0] ci_up,
  input wire logic [NUM_CH-1:0][NUM_IO-1:0] io_dir,
  input wire logic [NUM_CH-1:0][NUM_IO-1:0] pin_oe,
  input wire logic [NUM_CH-1:0] channel_active_flag,
  input wire logic [NUM_CH-1:0] voice_output_hiz,
  input wire logic [NUM_CH-1:0] voice_output_ref,
  input wire logic chopper_clk,
  input wire logic int_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_voice_active: assert property (
    1 |=> ((voice_output_hiz | voice_output_ref) & $past(channel_active_flag)) == '0)
    else $error("Idle voice mode seen on an active channel.");
  a_voice_excl: assert property (
    (voice_output_hiz & voice_output_ref) == '0)
    else $error("Voice output both floating and tied.");
  a_oe_copy: assert property (
    1 |=> pin_oe == $past(io_dir))
    else $error("Pin enable does not follow direction.");
  // Output CD1 and C3 pins must not leak their state into the upstream field.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ci
    a_ci_quiet: assert property (
      1 |=> !(ci_up[g][0] && $past(io_dir[g][IO_CD1])) && !(ci_up[g][2] && $past(io_dir[g][IO_C3])))
      else $error("Output pin echoed upstream.");
  end
  a_valid_pulse: assert property (
    up_valid |=> !up_valid)
    else $error("Answer strobe longer than one cycle.");
  a_byte_hold: assert property (
    $changed(up_byte) |-> up_valid)
    else $error("Answer byte changed without an answer.");
  a_chop_hold: assert property (
    $rose(chopper_clk) |=> chopper_clk [*8])
    else $error("Chopper half period too short.");
  a_int_clear: assert property (
    $rose(int_n) |-> $past(up_valid) || $past(up_valid, 2))
    else $error("Interrupt released without a clearing read.");
endmodule : gci_line_io_chk

`default_nettype wire

/* gci_ctrl_model.sv */
// Upstream controller model that sends link words one per link clock.
`timescale 1ns/10ps
`default_nettype none

module gci_ctrl_model
  import gci_line_io_pkg::*;
(
  output logic link_clk,
  output var link_word_t link_word
);
  initial begin
    link_clk = 1'b0;
    link_word = '0;
  end

  // The link clock stands still between words, so each word is one unit.
  task automatic send(input logic ci, input logic [1:0] ch, input logic [7:0] d);
    link_word = '{ci, ch, d};
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
    // Released lines show the inverse so a late sample cannot match by luck.
    link_word = ~link_word;
    // The gap keeps the inverse visible before the next word replaces it.
    #62.5;
  endtask : send
endmodule : gci_ctrl_model

`default_nettype wire

/* gci_line_io_config_regs_tb.sv */
// Self-checking bench for the line I/O register bank.
`timescale 1ns/10ps
`default_nettype none

module gci_line_io_config_regs_tb;
  import gci_line_io_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic link_clk, up_valid, int_n, strobe, chopper_clk;
  link_word_t link_word;
  logic [7:0] up_byte, got, v, e;
  logic [NUM_CH-1:0][2:0] ci_up;
  logic [NUM_CH-1:0][NUM_IO-1:0] io_dir = '0, ext = '0, pin_in, pin_out, pin_oe;
  logic [NUM_CH-1:0] c6, c7, hiz, vref, act = '0;
  logic [1:0] ch;
  logic [7:0] rcmd [5] = '{CMD_OPMODE_RD, CMD_DEB_RD, CMD_GK_RD, CMD_MASK_RD, CMD_RT_RD};
  logic [7:0] rrst [5] = '{OPMODE_RESET, DEB_RESET, 8'h00, MASK_RESET, 8'h00};
  logic [7:0] keep [4] = '{8'h30, 8'hfd, 8'h0f, 8'hff};
  int n_fail = 0, checks = 0, n_ans = 0;

  always #5 clock = ~clock;
  // A pin shows the driven level where enabled, the external level otherwise.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  gci_line_io_config_regs #(.MS_TICK_CYCLES(20)) i_dut (.clock(clock), .rst(rst),
    .link_clk(link_clk), .link_word(link_word), .up_valid(up_valid), .up_byte(up_byte),
    .ci_up(ci_up), .io_dir(io_dir), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .control_pin_six(c6), .control_pin_seven(c7), .channel_active_flag(act),
    .voice_output_hiz(hiz), .voice_output_ref(vref), .multiplex_strobe(strobe),
    .chopper_clk(chopper_clk), .int_n(int_n));
  gci_ctrl_model i_ctl (.link_clk(link_clk), .link_word(link_word));

  always @(posedge clock) begin
    if (up_valid === 1'b1) begin
      got <= up_byte;
      n_ans <= n_ans + 1;
    end
  end

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
    checks++;
    if (sn !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  task automatic results();
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_clk

  task automatic wr(input logic [7:0] cmd, input logic [1:0] c, input logic [7:0] d);
    i_ctl.send(1'b0, c, cmd);
    i_ctl.send(1'b0, c, d);
    wait_clk(4);
  endtask : wr

  task automatic rd(input logic [7:0] cmd, input logic [1:0] c);
    int n0;
    n0 = n_ans;
    i_ctl.send(1'b0, c, cmd);
    for (int i = 0; i < 20 && n_ans == n0; i++) @(negedge clock);
    chk("answers", 8'(n0 + 1), 8'(n_ans));
    if (n_ans == n0) results();
  endtask : rd

  initial begin
    void'($urandom(32'h49f2a269));
    repeat (6) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    chk("chopper", 8'h00, 8'(chopper_clk));
    foreach (rcmd[i]) begin
      rd(rcmd[i], 2'(i));
      chk("reset", rrst[i], got);
    end
    // Write commands are the read codes with the direction bit cleared.
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom()) & keep[k];
      wr(rcmd[k] & 8'hfe, 2'(k), v);
      rd(rcmd[k], 2'(k));
      chk("readback", v, got);
    end
    for (int m = 0; m < 2; m++) begin
      wr(CMD_OPMODE_WR, 2'd0, 8'(m << OPM_VOICE_OUTPUT_IDLE_MODE_BIT) | 8'h10);
      act = 4'($urandom());
      wait_clk(3);
      chk("hiz", 8'(~act & {4{m[0]}}), 8'(hiz));
      chk("ref", 8'(~act & {4{~m[0]}}), 8'(vref));
    end
    wr(CMD_GK_WR, 2'd0, 8'h00);
    wr(CMD_DEB_WR, 2'd0, 8'h01);
    chk("strobe", 8'h00, 8'(strobe));
    wr(CMD_DEB_WR, 2'd0, 8'h41);
    chk("strobe", 8'h01, 8'(strobe));
    for (int i = 0; i < 500 && chopper_clk !== 1'b1; i++) @(negedge clock);
    chk("chopper", 8'h01, 8'(chopper_clk));
    ext = (NUM_CH * NUM_IO)'($urandom());
    wait_clk(60);
    e = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      chk("ci", 8'({ext[c][IO_C3], ext[c][IO_CD2], ext[c][IO_CD1]}), 8'(ci_up[c]));
      rd(CMD_IO_RD, 2'(c));
      chk("io", {3'b000, ext[c]}, got & 8'hdf);
      e[2 * c] = ext[c][IO_CD1];
      e[2 * c + 1] = ext[c][IO_CD2];
    end
    rd(CMD_RT_RD, 2'd0);
    chk("rt", e, got);
    io_dir = '1;
    ch = 2'($urandom());
    v = 8'($urandom());
    e = 8'($urandom());
    wr(CMD_IO_WR, ch, v);
    chk("out", 8'(v[4:0]), 8'(pin_out[ch]));
    chk("c6", 8'(v[6]), 8'(c6[ch]));
    chk("c7", 8'(v[7]), 8'(c7[ch]));
    i_ctl.send(1'b1, ch, e);
    wait_clk(8);
    chk("out", 8'(e[4:0]), 8'(pin_out[ch]));
    rd(CMD_IO_RD, ch);
    chk("io", {v[7:6], 1'b0, e[4:0]}, got & 8'hdf);
    io_dir = '0;
    ext = '0;
    wr(CMD_MASK_WR, 2'd0, 8'h00);
    wait_clk(60);
    rd(CMD_RT_RD_CLR, 2'd0);
    wait_clk(3);
    chk("int", 8'h01, 8'(int_n));
    ext[0][IO_CD1] = 1'b1;
    wait_clk(60);
    chk("int", 8'h00, 8'(int_n));
    rd(CMD_RT_RD, 2'd0);
    wait_clk(3);
    chk("int", 8'h00, 8'(int_n));
    rd(CMD_RT_RD_CLR, 2'd0);
    wait_clk(3);
    chk("int", 8'h01, 8'(int_n));
    wr(CMD_MASK_WR, 2'd0, MASK_RESET);
    ext[0][IO_CD1] = 1'b0;
    wait_clk(60);
    chk("int", 8'h01, 8'(int_n));
    results();
  end
endmodule : gci_line_io_config_regs_tb

bind gci_line_io_config_regs gci_line_io_chk i_chk (.clock(clock), .rst(rst),
  .up_valid(up_valid), .up_byte(up_byte), .ci_up(ci_up), .io_dir(io_dir), .pin_oe(pin_oe),
  .channel_active_flag(channel_active_flag), .voice_output_hiz(voice_output_hiz),
  .voice_output_ref(voice_output_ref), .chopper_clk(chopper_clk), .int_n(int_n));

`default_nettype wire
